// ===== src/wlh_ctrl.sv
// Host serial port, general lines, converter reads and power modes behind a Wishbone slave
//
// How it works
// - Bit rate divisor, parity none/even/odd, stop bits and flow control are programmable.
// - Serial settings load at power-up from the nonvolatile storage input.
// - Request output and clear input are active low; each side pauses on deassertion.
// - Serial lines use non-inverted logic sense; transmit and receive idle high.
// - Frames are start, eight data, optional parity, stop, for a standard peer.
// - Nine two-way general lines are reachable from the host.
// - Each general line has its own direction bit.
// - Masked group write or read of general lines happens in one access.
// - Two converter channels each return a 10-bit result.
// - Converter results refresh at most five times per second.
// - Powersave lets the radio sleep except when receiving or exchanging traffic.
// - Mode 1 puts radio in powersave while the controller stays awake.
// - Mode 2: host deasserting data-set-ready sends controller to standby.
// - Standby ends on a packet from the access point or data-set-ready assertion.
// - Mode 5, radio powered down, is entered after start-up.
// - Wireless commands are refused while in mode 5.
// - Every general line is an input after reset.
// - Carrier-detect output is high when idle, low while the link is live.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "wlh_map.svh"
module wlh_ctrl #(
    parameter int ADC_PERIOD_CYC = `WLH_ADC_PERIOD_MS * `WLH_CLK_KHZ
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    input wire logic [19:0] nvCfg,
    input wire logic uartRx,
    output logic uartTx,
    input wire logic ctsN,
    output logic rtsN,
    input wire logic [8:0] generalLineIn,
    output logic [8:0] generalLineOut,
    output logic [8:0] generalLineOe,
    input wire logic [9:0] converterChannel0,
    input wire logic [9:0] converterChannel1,
    input wire logic dsrN,
    input wire logic packetArrive,
    input wire logic linkLive,
    output logic linkLiveOutN,
    output logic radioPowersave,
    output logic radioPowerDown,
    output logic ctrlStandby,
    output logic wirelessCmd
);
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic parityOf(input logic [7:0] d, input logic [1:0] mode);
        return (mode == `WLH_PAR_ODD) ? ~^d : ^d;
    endfunction

    // Reset release and pin synchronisers
    logic [1:0] rstPipe;
    logic rstN;
    logic [31:0] syncA, syncB;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            syncA <= `WLH_SYNC_RST;
            syncB <= `WLH_SYNC_RST;
        end else begin
            syncA <= {uartRx, ctsN, dsrN, generalLineIn, nvCfg};
            syncB <= syncA;
        end
    end
    wire rxS = syncB[31];
    wire ctsS = syncB[30];
    wire dsrS = syncB[29];
    wire [8:0] glS = syncB[28:20];
    wire [19:0] nvS = syncB[19:0];

    // Bus decode
    wire wbReq = wbCyc & wbStb & ~wbAck;
    wire wrEn = wbReq & wbWe;
    wire rdEn = wbReq & ~wbWe;
    wire hCfg = wbAdr == `WLH_A_CFG;
    wire hData = wbAdr == `WLH_A_DATA;
    wire hStat = wbAdr == `WLH_A_STAT;
    wire hDir = wbAdr == `WLH_A_DIR;
    wire hGpio = wbAdr == `WLH_A_GPIO;
    wire hAdc = wbAdr == `WLH_A_ADC;
    wire hPm = wbAdr == `WLH_A_PMODE;
    wire hCmd = wbAdr == `WLH_A_WCMD;

    // Configuration
    // Copies run until the synchronised defaults have reached syncB; the last copy wins
    logic [19:0] cfg;
    logic [1:0] loadCnt;
    wire [31:0] cfgMerged = mergeBytes({12'h0, cfg}, wbDatW, wbSel);
    wire [15:0] divisor = cfg[`WLH_CFG_DIV];
    wire [1:0] parMode = cfg[`WLH_CFG_PAR];
    wire parOn = parMode != `WLH_PAR_NONE;
    wire flowOn = cfg[`WLH_CFG_FLOW];
    wire [15:0] bitLoad = (divisor == 16'h0) ? 16'h0 : divisor - 16'h1;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cfg <= 20'h0;
            loadCnt <= 2'h0;
        end else if (loadCnt != `WLH_LOAD_AT) begin
            loadCnt <= loadCnt + 2'h1;
            cfg <= nvS;
        end else if (wrEn && hCfg) begin
            cfg <= cfgMerged[19:0];
        end
    end

    // Transmitter
    wlh_pkg::wlh_tx_t txState;
    logic [10:0] txSh;
    logic [3:0] txCnt;
    logic [15:0] txBaud;
    logic [7:0] txHold;
    logic txPending;
    // character finishes; start held while clear is high
    wire txGo = (txState == wlh_pkg::TX_IDLE) && txPending && !(flowOn && ctsS);
    // frame after start bit: data, parity, stops
    wire [10:0] txFrame = {2'b11, parOn ? parityOf(txHold, parMode) : 1'b1, txHold};
    wire [3:0] txLen = 4'h9 + {3'h0, parOn} + {3'h0, cfg[`WLH_CFG_STOP2]};
    wire txLoad = wrEn && hData && wbSel[0] && !txPending;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            txPending <= 1'b0;
            txHold <= 8'h0;
        end else if (txLoad) begin
            txPending <= 1'b1;
            txHold <= wbDatW[7:0];
        end else if (txGo) begin
            txPending <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            txState <= wlh_pkg::TX_IDLE;
            uartTx <= 1'b1;
            txSh <= 11'h7ff;
            txCnt <= 4'h0;
            txBaud <= 16'h0;
        end else if (txState == wlh_pkg::TX_IDLE) begin
            // line idles high, start bit low
            uartTx <= !txGo;
            txSh <= txFrame;
            txCnt <= txLen;
            txBaud <= bitLoad;
            if (txGo) begin
                txState <= wlh_pkg::TX_SHIFT;
            end
        end else if (txBaud != 16'h0) begin
            txBaud <= txBaud - 16'h1;
        end else if (txCnt == 4'h0) begin
            uartTx <= 1'b1;
            txState <= wlh_pkg::TX_IDLE;
        end else begin
            uartTx <= txSh[0];
            txSh <= {1'b1, txSh[10:1]};
            txCnt <= txCnt - 4'h1;
            txBaud <= bitLoad;
        end
    end

    // Receiver
    wlh_pkg::wlh_rx_t rxState;
    logic [9:0] rxSh;
    logic [3:0] rxCnt;
    logic [15:0] rxBaud;
    logic [7:0] rxData;
    logic rxFull, parErr, frameErr, overrun;
    wire [7:0] rxByte = parOn ? rxSh[7:0] : rxSh[8:1];
    wire rxDone = rxState == wlh_pkg::RX_DONE;
    wire rxBad = parOn && (rxSh[8] != parityOf(rxSh[7:0], parMode));
    wire rdData = rdEn && hData;
    wire stClr = wrEn && hStat;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rxState <= wlh_pkg::RX_IDLE;
            rxSh <= 10'h0;
            rxCnt <= 4'h0;
            rxBaud <= 16'h0;
        end else begin
            unique case (rxState)
                wlh_pkg::RX_IDLE: begin
                    rxBaud <= {1'b0, divisor[15:1]};
                    if (!rxS) begin
                        rxState <= wlh_pkg::RX_START;
                    end
                end
                wlh_pkg::RX_START: begin
                    rxBaud <= (rxBaud == 16'h0) ? bitLoad : rxBaud - 16'h1;
                    rxCnt <= 4'h9 + {3'h0, parOn};
                    if (rxBaud == 16'h0) begin
                        rxState <= rxS ? wlh_pkg::RX_IDLE : wlh_pkg::RX_BITS;
                    end
                end
                wlh_pkg::RX_BITS: begin
                    rxBaud <= (rxBaud == 16'h0) ? bitLoad : rxBaud - 16'h1;
                    if (rxBaud == 16'h0) begin
                        rxSh <= {rxS, rxSh[9:1]};
                        rxCnt <= rxCnt - 4'h1;
                        if (rxCnt == 4'h1) begin
                            rxState <= wlh_pkg::RX_DONE;
                        end
                    end
                end
                wlh_pkg::RX_DONE: begin
                    rxState <= wlh_pkg::RX_IDLE;
                end
            endcase
        end
    end
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rxFull <= 1'b0;
            rxData <= 8'h0;
            parErr <= 1'b0;
            frameErr <= 1'b0;
            overrun <= 1'b0;
        end else begin
            rxFull <= (rxDone && !rxFull) || (rxFull && !rdData) || (rxDone && rxFull);
            if (rxDone && !rxFull) begin
                rxData <= rxByte;
            end
            parErr <= (rxDone && rxBad) || (parErr && !(stClr && wbDatW[3]));
            frameErr <= (rxDone && !rxSh[9]) || (frameErr && !(stClr && wbDatW[4]));
            overrun <= (rxDone && rxFull) || (overrun && !(stClr && wbDatW[5]));
        end
    end
    // request deasserted while the receive byte is unread
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rtsN <= 1'b1;
        end else begin
            rtsN <= flowOn && rxFull;
        end
    end

    // General lines
    wire [8:0] grpMask = wbDatW[`WLH_GPIO_MASK];
    wire [8:0] grpVal = wbDatW[`WLH_GPIO_VAL];
    wire [31:0] dirMerged = mergeBytes({23'h0, generalLineOe}, wbDatW, wbSel);
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            generalLineOe <= 9'h0;
            generalLineOut <= 9'h0;
        end else begin
            if (wrEn && hDir) begin
                generalLineOe <= dirMerged[8:0];
            end
            if (wrEn && hGpio) begin
                generalLineOut <= (generalLineOut & ~grpMask) | (grpVal & grpMask);
            end
        end
    end

    // Converter sampling
    logic [25:0] adcCnt;
    logic [9:0] adc0, adc1;
    logic adcFresh;
    wire adcTake = adcCnt == 26'h0;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            adcCnt <= 26'h0;
            adc0 <= 10'h0;
            adc1 <= 10'h0;
            adcFresh <= 1'b0;
        end else begin
            adcCnt <= adcTake ? 26'(ADC_PERIOD_CYC - 1) : adcCnt - 26'h1;
            adcFresh <= adcTake || (adcFresh && !(rdEn && hAdc));
            if (adcTake) begin
                adc0 <= converterChannel0;
                adc1 <= converterChannel1;
            end
        end
    end

    // Power modes
    logic [2:0] pmode;
    logic dsrPrev, cmdRefused;
    wire [2:0] pmReq = wbDatW[2:0];
    wire pmLegal = (pmReq == `WLH_PM_ACTIVE) || (pmReq == `WLH_PM_RADIO_PS) ||
                   (pmReq == `WLH_PM_STANDBY) || (pmReq == `WLH_PM_RADIO_OFF);
    wire inStandbyMode = pmode == `WLH_PM_STANDBY;
    wire cmdWr = wrEn && hCmd;
    wire radioOff = pmode == `WLH_PM_RADIO_OFF;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pmode <= `WLH_PM_RADIO_OFF;
            dsrPrev <= 1'b1;
            ctrlStandby <= 1'b0;
            radioPowersave <= 1'b0;
            radioPowerDown <= 1'b1;
            cmdRefused <= 1'b0;
            wirelessCmd <= 1'b0;
            linkLiveOutN <= 1'b1;
        end else begin
            if (wrEn && hPm && wbSel[0] && pmLegal) begin
                pmode <= pmReq;
            end
            dsrPrev <= dsrS;
            // enter on deassertion; leave on packet or assertion
            if (!inStandbyMode || packetArrive || !dsrS) begin
                ctrlStandby <= 1'b0;
            end else if (!dsrPrev) begin
                ctrlStandby <= 1'b1;
            end
            // radio sleeps between receptions; mode 1 controller awake
            radioPowersave <= (pmode == `WLH_PM_RADIO_PS) || inStandbyMode;
            radioPowerDown <= radioOff;
            // wireless commands refused in mode 5
            wirelessCmd <= cmdWr && !radioOff;
            cmdRefused <= (cmdWr && radioOff) || (cmdRefused && !(stClr && wbDatW[6]));
            linkLiveOutN <= !linkLive;
        end
    end

    // Bus answer: one wait state, unmapped reads give zero
    wire [31:0] statWord = {24'h0, ctrlStandby, cmdRefused, overrun, frameErr, parErr, rxFull,
                            txState == wlh_pkg::TX_SHIFT, txPending};
    wire [31:0] rdMux = hCfg ? {12'h0, cfg} :
                        hData ? {24'h0, rxData} :
                        hStat ? statWord :
                        hDir ? {23'h0, generalLineOe} :
                        hGpio ? {23'h0, glS} :
                        hAdc ? {adcFresh, 5'h0, adc1, 6'h0, adc0} :
                        hPm ? {29'h0, pmode} : 32'h0;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0;
        end else begin
            wbAck <= wbReq;
            wbDatR <= rdEn ? rdMux : 32'h0;
        end
    end

    // Checks
    logic [25:0] adcGap;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            adcGap <= 26'h0;
        end else begin
            adcGap <= adcTake ? 26'h0 : adcGap + 26'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstN);
    property p_txIdleHigh;
        txState == wlh_pkg::TX_IDLE |-> uartTx;
    endproperty
    a_txIdleHigh: assert property (p_txIdleHigh) else $error("transmit line low while idle");
    property p_ctsHold;
        (txState == wlh_pkg::TX_IDLE && flowOn && ctsS) |=> txState == wlh_pkg::TX_IDLE && uartTx;
    endproperty
    a_ctsHold: assert property (p_ctsHold) else $error("character started without clear");
    property p_dirWrite;
        (wrEn && hDir) |=> generalLineOe == $past(dirMerged[8:0]);
    endproperty
    a_dirWrite: assert property (p_dirWrite) else $error("direction write lost");
    property p_groupWrite;
        (wrEn && hGpio) |=> ((generalLineOut ^ $past(grpVal)) & $past(grpMask)) == 9'h0;
    endproperty
    a_groupWrite: assert property (p_groupWrite) else $error("masked lines not written together");
    property p_pmIgnore;
        (wrEn && hPm && !pmLegal) |=> $stable(pmode);
    endproperty
    a_pmIgnore: assert property (p_pmIgnore) else $error("illegal power mode accepted");
    property p_startMode;
        $rose(rstN) |-> pmode == `WLH_PM_RADIO_OFF ##1 radioPowerDown;
    endproperty
    a_startMode: assert property (p_startMode) else $error("not in mode 5 after reset");
    property p_refuse;
        (cmdWr && radioOff) |=> cmdRefused && !wirelessCmd;
    endproperty
    a_refuse: assert property (p_refuse) else $error("wireless command passed in mode 5");
    property p_wake;
        (ctrlStandby && (packetArrive || !dsrS)) |=> !ctrlStandby;
    endproperty
    a_wake: assert property (p_wake) else $error("standby not left on wake");
    property p_carrier;
        linkLive |=> !linkLiveOutN;
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier detect not low while live");
    property p_adcRate;
        (adcTake && adcFresh && $past(adcTake) == 1'b0) |-> adcGap == 26'(ADC_PERIOD_CYC - 1);
    endproperty
    a_adcRate: assert property (p_adcRate) else $error("converter refreshed too fast");
    c_txFrame: cover property (txGo ##1 txState == wlh_pkg::TX_SHIFT);
    c_rxByte: cover property (rxDone && !rxFull);
    c_standby: cover property ($rose(ctrlStandby));
endmodule // wlh_ctrl

// ===== common/wlh_map.svh
// Register offsets, field positions, reset values and timing for the host serial block
`ifndef WLH_MAP_SVH
`define WLH_MAP_SVH
`define WLH_CLK_KHZ 200000
`define WLH_ADC_PERIOD_MS 200
`define WLH_A_CFG 8'h00
`define WLH_A_DATA 8'h04
`define WLH_A_STAT 8'h08
`define WLH_A_DIR 8'h0c
`define WLH_A_GPIO 8'h10
`define WLH_A_ADC 8'h14
`define WLH_A_PMODE 8'h18
`define WLH_A_WCMD 8'h1c
`define WLH_CFG_DIV 15:0
`define WLH_CFG_PAR 17:16
`define WLH_CFG_STOP2 18
`define WLH_CFG_FLOW 19
`define WLH_PAR_NONE 2'h0
`define WLH_PAR_ODD 2'h2
`define WLH_ST_W1C 32'h00000078
`define WLH_GPIO_VAL 8:0
`define WLH_GPIO_MASK 24:16
`define WLH_PM_ACTIVE 3'h0
`define WLH_PM_RADIO_PS 3'h1
`define WLH_PM_STANDBY 3'h2
`define WLH_PM_RADIO_OFF 3'h5
`define WLH_SYNC_RST 32'he0000000
`define WLH_LOAD_AT 2'h3
`define WLH_ADC_FRESH 31
`endif

// ===== common/wlh_pkg.sv
// State types for the host serial block
package wlh_pkg;
    typedef enum logic {TX_IDLE, TX_SHIFT} wlh_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_DONE} wlh_rx_t;
endpackage

// ===== tb/wlh_host_model.sv
// Host-side serial peer: sends and receives characters, drives handshake lines
`timescale 1ns/1ps
module wlh_host_model #(
    parameter int DIV = 4
) (
    input wire logic clk_sys,
    input wire logic uartTx,
    input wire logic rtsN,
    output logic uartRx,
    output logic ctsN,
    output logic dsrN
);
    logic [7:0] rxByte;
    int rxCount;
    initial begin
        uartRx = 1'b1;
        ctsN = 1'b1;
        dsrN = 1'b0;
        rxByte = 8'h00;
        rxCount = 0;
    end
    task automatic setCts(input logic v);
        @(posedge clk_sys);
        ctsN <= v;
    endtask
    task automatic setDsr(input logic v);
        @(posedge clk_sys);
        dsrN <= v;
    endtask
    // waits for request, then frames LSB first
    task automatic send(input logic [7:0] b);
        int t;
        t = 0;
        while (rtsN !== 1'b0 && t < 1000) begin
            @(posedge clk_sys);
            t++;
        end
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            uartRx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
            repeat (DIV - 1) @(posedge clk_sys);
        end
    endtask
    always begin
        @(negedge uartTx);
        repeat (DIV / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk_sys);
            rxByte[i] = uartTx;
        end
        repeat (DIV) @(posedge clk_sys);
        rxCount++;
    end
endmodule // wlh_host_model

// ===== tb/test_wlh_ctrl.sv
// Self-checking bench for the host serial block
`timescale 1ns/1ps
`include "wlh_map.svh"
module test_wlh_ctrl;
    typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat;} wlh_row_t;
    logic clk_sys, nrst, wbCyc, wbStb, wbWe, wbAck, uartRx, uartTx, ctsN, rtsN, dsrN;
    logic packetArrive, linkLive, linkLiveOutN, radioPowersave, radioPowerDown, ctrlStandby, wirelessCmd;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, d;
    logic [8:0] generalLineIn, generalLineOut, generalLineOe;
    logic [9:0] ch0, ch1;
    logic [19:0] nvCfg;
    int nMismatch, nChecks, nCmd, t;
    wlh_row_t rows[14] = '{'{1'b1, `WLH_A_DIR, 32'h1a5}, '{1'b0, `WLH_A_DIR, 32'h1a5},
        '{1'b1, `WLH_A_PMODE, 32'h1}, '{1'b0, `WLH_A_PMODE, 32'h1}, '{1'b1, `WLH_A_PMODE, 32'h3},
        '{1'b0, `WLH_A_PMODE, 32'h1}, '{1'b1, `WLH_A_PMODE, 32'h2}, '{1'b0, `WLH_A_PMODE, 32'h2},
        '{1'b1, `WLH_A_PMODE, 32'h5}, '{1'b0, `WLH_A_PMODE, 32'h5}, '{1'b1, 8'h20, 32'hffffffff},
        '{1'b0, 8'h20, 32'h0}, '{1'b1, `WLH_A_PMODE, 32'h0}, '{1'b0, `WLH_A_PMODE, 32'h0}};

    wlh_ctrl #(.ADC_PERIOD_CYC(1000)) dut (.clk_sys(clk_sys), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
        .nvCfg(nvCfg), .uartRx(uartRx), .uartTx(uartTx), .ctsN(ctsN), .rtsN(rtsN),
        .generalLineIn(generalLineIn), .generalLineOut(generalLineOut), .generalLineOe(generalLineOe),
        .converterChannel0(ch0), .converterChannel1(ch1), .dsrN(dsrN), .packetArrive(packetArrive),
        .linkLive(linkLive), .linkLiveOutN(linkLiveOutN), .radioPowersave(radioPowersave),
        .radioPowerDown(radioPowerDown), .ctrlStandby(ctrlStandby), .wirelessCmd(wirelessCmd));
    wlh_host_model #(.DIV(4)) hm (.clk_sys(clk_sys), .uartTx(uartTx), .rtsN(rtsN), .uartRx(uartRx),
        .ctsN(ctsN), .dsrN(dsrN));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (wirelessCmd === 1'b1) nCmd++;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Holds the request until ack is sampled, then releases
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hf);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= dat;
        @(posedge clk_sys);
        while (wbAck !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        // A missing answer counts against the run
        if (wbAck !== 1'b1) begin
            nMismatch++;
        end
        d = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] m);
        wb(1'b0, adr, 32'h0);
        chk(name, exp, d & m);
    endtask
    task automatic waitRx(input int n);
        t = 0;
        while (hm.rxCount < n && t < 2000) begin
            @(posedge clk_sys);
            t++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge clk_sys);
        nMismatch++;
        finish_test;
    end

    initial begin
        {nrst, wbCyc, wbStb, wbWe, packetArrive, linkLive} = 6'h0;
        wbAdr = 8'h00;
        wbSel = 4'hf;
        wbDatW = 32'h0;
        generalLineIn = 9'h155;
        ch0 = 10'h3ff;
        ch1 = 10'h12a;
        nvCfg = 20'h80004;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("lineOe", 32'h0, {23'h0, generalLineOe}); // all inputs
        chk("powerDown", 32'h1, {31'h0, radioPowerDown}); // start-up mode
        chk("linkOutN", 32'h1, {31'h0, linkLiveOutN}); // idle high
        chk("txIdle", 32'h1, {31'h0, uartTx}); // idle high
        rdchk("cfg", `WLH_A_CFG, 32'h00080004, 32'hffffffff); // loaded settings
        foreach (rows[i]) begin
            if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].dat);
            else rdchk("table", rows[i].adr, rows[i].dat, 32'hffffffff); // readback
        end
        wb(1'b1, `WLH_A_DIR, 32'h1ff);
        wb(1'b1, `WLH_A_GPIO, 32'h000f01ff);
        chk("lineOut", 32'h00f, {23'h0, generalLineOut}); // masked group
        wb(1'b1, `WLH_A_GPIO, 32'h01f000a0);
        chk("lineOut2", 32'h0af, {23'h0, generalLineOut}); // others kept
        chk("lineOe2", 32'h1ff, {23'h0, generalLineOe}); // all driven
        rdchk("lineIn", `WLH_A_GPIO, 32'h155, 32'h1ff); // group sample
        rdchk("adc", `WLH_A_ADC, 32'h812a03ff, 32'h83ff03ff); // both channels
        rdchk("adcFresh", `WLH_A_ADC, 32'h0, 32'h80000000); // no new sample yet
        wb(1'b1, `WLH_A_DATA, 32'ha6);
        repeat (60) @(posedge clk_sys);
        chk("txHeld", 32'h0, hm.rxCount); // clear deasserted
        hm.setCts(1'b0);
        t = 0;
        while (uartTx !== 1'b0 && t < 100) begin
            @(posedge clk_sys);
            t++;
        end
        hm.setCts(1'b1);
        wb(1'b1, `WLH_A_DATA, 32'h5b);
        waitRx(1);
        chk("txByte", 32'ha6, hm.rxByte); // finishes character
        repeat (60) @(posedge clk_sys);
        chk("txHeld2", 32'h1, hm.rxCount); // next one held
        hm.setCts(1'b0);
        waitRx(2);
        chk("txByte2", 32'h5b, hm.rxByte); // resumes
        hm.send(8'h3c);
        repeat (12) @(posedge clk_sys);
        rdchk("rxFull", `WLH_A_STAT, 32'h4, 32'h4); // byte arrived
        chk("rtsHigh", 32'h1, {31'h0, rtsN}); // pause peer
        rdchk("rxByte", `WLH_A_DATA, 32'h3c, 32'hff); // byte value
        repeat (4) @(posedge clk_sys);
        chk("rtsLow", 32'h0, {31'h0, rtsN}); // ready again
        wb(1'b1, `WLH_A_PMODE, 32'h2);
        hm.setDsr(1'b1);
        repeat (8) @(posedge clk_sys);
        chk("standby", 32'h1, {31'h0, ctrlStandby}); // host permits
        chk("psave2", 32'h1, {31'h0, radioPowersave}); // radio powersave
        packetArrive <= 1'b1;
        @(posedge clk_sys);
        packetArrive <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("wakePkt", 32'h0, {31'h0, ctrlStandby}); // packet wake
        hm.setDsr(1'b0);
        repeat (6) @(posedge clk_sys);
        hm.setDsr(1'b1);
        repeat (8) @(posedge clk_sys);
        chk("standby2", 32'h1, {31'h0, ctrlStandby}); // again
        hm.setDsr(1'b0);
        repeat (8) @(posedge clk_sys);
        chk("wakeDsr", 32'h0, {31'h0, ctrlStandby}); // host wake
        wb(1'b1, `WLH_A_PMODE, 32'h5);
        t = nCmd;
        wb(1'b1, `WLH_A_WCMD, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk("cmdRefused", t, nCmd); // no pulse
        rdchk("refusedFlag", `WLH_A_STAT, 32'h40, 32'h40); // flagged
        chk("powerDown5", 32'h1, {31'h0, radioPowerDown}); // radio off
        wb(1'b1, `WLH_A_PMODE, 32'h1);
        wb(1'b1, `WLH_A_WCMD, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk("cmdTaken", t + 1, nCmd); // controller awake
        chk("psave1", 32'h1, {31'h0, radioPowersave}); // radio sleeps
        linkLive <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("linkLive", 32'h0, {31'h0, linkLiveOutN}); // low while live
        // Second reset: new defaults, pin levels and converter inputs must all be picked up
        nvCfg <= 20'h90004;
        generalLineIn <= 9'h0aa;
        ch0 <= 10'h155;
        ch1 <= 10'h2aa;
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("linkOutRst", 32'h1, {31'h0, linkLiveOutN}); // idle in reset
        nrst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rdchk("cfg2", `WLH_A_CFG, 32'h00090004, 32'hffffffff); // reloaded defaults
        rdchk("lineIn2", `WLH_A_GPIO, 32'h0aa, 32'h1ff); // new pin levels
        rdchk("adc2", `WLH_A_ADC, 32'h82aa0155, 32'h83ff03ff); // new sample
        wb(1'b1, `WLH_A_PMODE, 32'h1, 4'he);
        rdchk("pmSel", `WLH_A_PMODE, 32'h5, 32'h7); // needs byte 0
        wb(1'b1, `WLH_A_DIR, 32'h1ff, 4'h1);
        rdchk("dirSel", `WLH_A_DIR, 32'h0ff, 32'h1ff); // byte enables
        // Plain frame into an even-parity receiver: the stop bit lands in the parity slot
        hm.send(8'h3c);
        repeat (12) @(posedge clk_sys);
        rdchk("parErr", `WLH_A_STAT, 32'hc, 32'hc); // even parity checked
        rdchk("rxByte2", `WLH_A_DATA, 32'h3c, 32'hff); // parity framing
        finish_test;
    end
endmodule // test_wlh_ctrl
